// *** rtl/adc_conversion_serial_control.sv ***
// conversion control and serial result framing, link side on master clock
`timescale 1ns/100ps
`include "adc_defs.svh"

module adc_conversion_serial_control (
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic         i_master_clock_in,
   input  wire logic         i_chip_select_n,
   input  wire logic         i_convert_start_n,
   input  wire logic         i_mode,
   input  wire logic         i_shift_clock_invert_n,
   input  wire logic         i_frame_polarity_invert_n,
   input  wire adc_pkg::code_t i_sample_code,
   output logic              o_shift_clock,
   output logic              o_shift_clock_oe,
   output logic              o_serial_result_out,
   output logic              o_serial_result_out_oe,
   output logic              o_frame_window,
   output logic              o_frame_window_oe,
   output logic              o_frame_start_pulse,
   output logic              o_frame_start_pulse_oe,
   output logic              o_hold_active,
   output adc_pkg::code_t    o_result_word,
   output logic              o_result_valid
);

   logic [`ADC_SYNC_WIDTH-1:0] pins_raw;
   logic [`ADC_SYNC_WIDTH-1:0] pins_s;

   logic                 lrst;
   logic                 cs_n_s;
   logic                 cv_n_s;
   logic                 mode_s;
   logic                 clkinv_n_s;
   logic                 polinv_n_s;
   logic                 start_lvl;
   logic                 start_edge;
   logic                 want_start;
   adc_pkg::code_t       code_src;
   adc_pkg::code_t       trial;
   logic                 keep;

   adc_pkg::conv_state_e state_r;
   adc_pkg::conv_state_e state_nxt;
   logic [3:0]           cnt_r;
   logic [3:0]           cnt_nxt;
   adc_pkg::code_t       mask_r;
   adc_pkg::code_t       mask_nxt;
   adc_pkg::code_t       successive_approx_reg_r;
   adc_pkg::code_t       successive_approx_reg_nxt;
   adc_pkg::code_t       held_r;
   adc_pkg::code_t       held_nxt;
   adc_pkg::code_t       result_r;
   adc_pkg::code_t       result_nxt;
   logic                 hold_r;
   logic                 hold_nxt;
   logic                 tgl_r;
   logic                 tgl_nxt;
   logic                 start_lvl_r;
   logic                 start_lvl_nxt;
   logic                 mode_taken_r;
   logic                 mode_taken_nxt;
   logic                 cont_r;
   logic                 cont_nxt;
   logic                 serial_r;
   logic                 serial_nxt;
   logic                 frame_start_pulse_r;
   logic                 frame_start_pulse_nxt;
   logic                 window_r;
   logic                 window_nxt;
   logic                 oe_r;
   logic                 oe_nxt;

   logic                 tgl_s;
   logic                 tgl_seen_r;
   logic                 tgl_seen_nxt;
   adc_pkg::code_t       word_r;
   adc_pkg::code_t       word_nxt;
   logic                 valid_r;
   logic                 valid_nxt;

   // pins and the system reset into the master clock domain
   assign pins_raw[`ADC_SYNC_CS]     = i_chip_select_n;
   assign pins_raw[`ADC_SYNC_CV]     = i_convert_start_n;
   assign pins_raw[`ADC_SYNC_MODE]   = i_mode;
   assign pins_raw[`ADC_SYNC_CLKINV] = i_shift_clock_invert_n;
   assign pins_raw[`ADC_SYNC_POLINV] = i_frame_polarity_invert_n;
   assign pins_raw[`ADC_SYNC_RST]    = i_rst;

   genvar gi;
   generate
      for (gi = 0; gi < `ADC_SYNC_WIDTH; gi = gi + 1) begin : g_sync
         sync_2ff u_sync (
            .i_clock (i_master_clock_in),
            .i_d     (pins_raw[gi]),
            .o_q     (pins_s[gi])
         );
      end
   endgenerate

   assign cs_n_s     = pins_s[`ADC_SYNC_CS];
   assign cv_n_s     = pins_s[`ADC_SYNC_CV];
   assign mode_s     = pins_s[`ADC_SYNC_MODE];
   assign clkinv_n_s = pins_s[`ADC_SYNC_CLKINV];
   assign polinv_n_s = pins_s[`ADC_SYNC_POLINV];
   assign lrst       = pins_s[`ADC_SYNC_RST];

   // start is taken at a rising master edge, so pin timing against the
   // edge sets the start cycle; synchroniser adds fixed latency
   assign start_lvl  = ~cs_n_s & ~cv_n_s;
   assign start_edge = start_lvl & ~start_lvl_r;
   // single modes need a fresh joint fall; continuous runs on the level
   assign want_start = mode_taken_r &
                       (cont_r ? start_lvl : start_edge);

   // comparator sees the held sample once hold is on
   assign code_src = hold_r ? held_r : i_sample_code;
   assign trial    = successive_approx_reg_r | mask_r;
   assign keep     = (code_src >= trial);

   always_comb begin
      state_nxt                 = state_r;
      cnt_nxt                   = cnt_r;
      mask_nxt                  = mask_r;
      successive_approx_reg_nxt = successive_approx_reg_r;
      held_nxt                  = held_r;
      hold_nxt                  = hold_r;
      result_nxt                = result_r;
      tgl_nxt                   = tgl_r;
      serial_nxt                = 1'b0;
      start_lvl_nxt             = start_lvl;
      mode_taken_nxt            = 1'b1;
      cont_nxt                  = cont_r;
      // mode pin counts only once, just after reset release
      if (!mode_taken_r) begin
         cont_nxt = ~mode_s;
      end
      unique case (state_r)
         adc_pkg::ST_IDLE: begin
            // starts outside idle are ignored, except the start level in the last continuous tail cycle
            if (want_start) begin
               state_nxt                 = adc_pkg::ST_START;
               // continuous mode keeps tracking through the pulse cycle
               hold_nxt                  = ~cont_r;
               mask_nxt                  = `ADC_MSB_MASK;
               successive_approx_reg_nxt = '0;
            end
         end
         adc_pkg::ST_START: begin
            state_nxt                 = adc_pkg::ST_BITS;
            cnt_nxt                   = `ADC_CNT_RESET;
            hold_nxt                  = 1'b1;
            successive_approx_reg_nxt = keep ? trial
                                             : successive_approx_reg_r;
            // sign bit flipped: offset code out as two's complement
            serial_nxt                = ~keep;
            mask_nxt                  = mask_r >> 1;
         end
         adc_pkg::ST_BITS: begin
            if (cnt_r == `ADC_LAST_BIT_CNT) begin
               state_nxt  = adc_pkg::ST_TAIL;
               cnt_nxt    = `ADC_CNT_RESET;
               hold_nxt   = 1'b0;
               result_nxt = {~successive_approx_reg_r[`ADC_RESULT_BITS-1],
                             successive_approx_reg_r[`ADC_RESULT_BITS-2:0]};
               tgl_nxt    = ~tgl_r;
            end else begin
               cnt_nxt                   = cnt_r + 4'h1;
               successive_approx_reg_nxt = keep ? trial
                                                : successive_approx_reg_r;
               serial_nxt                = keep;
               mask_nxt                  = mask_r >> 1;
            end
         end
         adc_pkg::ST_TAIL: begin
            // trailing zeros double as the acquisition cycles
            if (cnt_r == (cont_r ? `ADC_TAIL_CONT_LAST
                                 : `ADC_TAIL_SINGLE_LAST)) begin
               if (cont_r && start_lvl) begin
                  state_nxt                 = adc_pkg::ST_START;
                  mask_nxt                  = `ADC_MSB_MASK;
                  successive_approx_reg_nxt = '0;
               end else begin
                  state_nxt = adc_pkg::ST_IDLE;
               end
            end else begin
               cnt_nxt = cnt_r + 4'h1;
            end
         end
      endcase
      // sample is frozen on the edge that enters hold
      if (hold_nxt && !hold_r) begin
         held_nxt = i_sample_code;
      end
   end

   always_comb begin
      frame_start_pulse_nxt  = (state_nxt == adc_pkg::ST_START);
      // window covers the bit and tail states, never in continuous mode
      window_nxt = ~cont_nxt &
                   ((state_nxt == adc_pkg::ST_BITS) |
                    (state_nxt == adc_pkg::ST_TAIL));
      window_nxt = window_nxt ^ polinv_n_s;
      oe_nxt     = ~cs_n_s;
   end

   always_ff @(posedge i_master_clock_in) begin
      if (lrst) begin
         state_r                 <= adc_pkg::ST_IDLE;
         cnt_r                   <= `ADC_CNT_RESET;
         mask_r                  <= '0;
         successive_approx_reg_r <= '0;
         held_r                  <= '0;
         hold_r                  <= 1'b0;
         result_r                <= '0;
         tgl_r                   <= 1'b0;
         start_lvl_r             <= 1'b1;
         mode_taken_r            <= 1'b0;
         cont_r                  <= 1'b0;
         serial_r                <= 1'b0;
         frame_start_pulse_r                 <= 1'b0;
         window_r                <= 1'b0;
         oe_r                    <= 1'b0;
      end else begin
         state_r                 <= state_nxt;
         cnt_r                   <= cnt_nxt;
         mask_r                  <= mask_nxt;
         successive_approx_reg_r <= successive_approx_reg_nxt;
         held_r                  <= held_nxt;
         hold_r                  <= hold_nxt;
         result_r                <= result_nxt;
         tgl_r                   <= tgl_nxt;
         start_lvl_r             <= start_lvl_nxt;
         mode_taken_r            <= mode_taken_nxt;
         cont_r                  <= cont_nxt;
         serial_r                <= serial_nxt;
         frame_start_pulse_r                 <= frame_start_pulse_nxt;
         window_r                <= window_nxt;
         oe_r                    <= oe_nxt;
      end
   end

   // free-running shift clock; phase set by the invert pin
   assign o_shift_clock = i_master_clock_in ^ ~clkinv_n_s;
   assign o_shift_clock_oe       = oe_r;
   assign o_serial_result_out    = serial_r;
   assign o_serial_result_out_oe = oe_r;
   assign o_frame_window         = window_r;
   assign o_frame_window_oe      = oe_r;
   assign o_frame_start_pulse    = frame_start_pulse_r;
   assign o_frame_start_pulse_oe = oe_r;
   assign o_hold_active          = hold_r;

   // result word to the system clock: toggle event, word is stable for
   // at least sixteen master cycles after the toggle moves
   sync_2ff u_tgl_sync (
      .i_clock (i_clock),
      .i_d     (tgl_r),
      .o_q     (tgl_s)
   );

   always_comb begin
      tgl_seen_nxt = tgl_s;
      word_nxt     = word_r;
      valid_nxt    = 1'b0;
      if (tgl_s != tgl_seen_r) begin
         word_nxt  = result_r;
         valid_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tgl_seen_r <= 1'b0;
         word_r     <= '0;
         valid_r    <= 1'b0;
      end else begin
         tgl_seen_r <= tgl_seen_nxt;
         word_r     <= word_nxt;
         valid_r    <= valid_nxt;
      end
   end

   assign o_result_word  = word_r;
   assign o_result_valid = valid_r;

endmodule : adc_conversion_serial_control

// *** rtl/adc_defs.svh ***
// constants for the conversion control and serial framing block
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define ADC_RESULT_BITS      14
`define ADC_FRAME_BITS       16
`define ADC_MSB_MASK         14'h2000
`define ADC_LAST_BIT_CNT     4'hD
`define ADC_TAIL_SINGLE_LAST 4'h1
`define ADC_TAIL_CONT_LAST   4'h0
`define ADC_CNT_RESET        4'h0

`define ADC_ACQ_NS           400
`define ADC_CLK_NS           8
`define ADC_ACQ_CYCLES       ((`ADC_ACQ_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`define ADC_SYNC_WIDTH       6
`define ADC_SYNC_CS          0
`define ADC_SYNC_CV          1
`define ADC_SYNC_MODE        2
`define ADC_SYNC_CLKINV      3
`define ADC_SYNC_POLINV      4
`define ADC_SYNC_RST         5

`endif

// *** rtl/adc_pkg.sv ***
// types for the conversion control and serial framing block
package adc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_BITS  = 2'b10,
      ST_TAIL  = 2'b11
   } conv_state_e;

   typedef logic [13:0] code_t;

endpackage : adc_pkg

// *** rtl/sync_2ff.sv ***
// two flip-flop level synchroniser
`timescale 1ns/100ps

module sync_2ff (
   input  wire logic i_clock,
   input  wire logic i_d,
   output logic      o_q
);

   logic meta_r;
   logic meta_nxt;
   logic q_r;
   logic q_nxt;

   // no reset: the chain settles within two edges of any clock
   always_comb begin
      meta_nxt = i_d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge i_clock) begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
   end

   assign o_q = q_r;

endmodule : sync_2ff

// *** bench/adc_ctl_sva.sv ***
// checker for conversion framing, output enables and track/hold timing
`timescale 1ns/100ps
module adc_ctl_sva (
   input  wire logic i_master_clock_in,
   input  wire logic i_rst,
   input  wire logic i_chip_select_n,
   input  wire logic i_mode,
   input  wire logic i_frame_polarity_invert_n,
   input  wire logic o_shift_clock_oe,
   input  wire logic o_serial_result_out,
   input  wire logic o_serial_result_out_oe,
   input  wire logic o_frame_window,
   input  wire logic o_frame_window_oe,
   input  wire logic o_frame_start_pulse,
   input  wire logic o_frame_start_pulse_oe,
   input  wire logic o_hold_active
);
   default clocking cb @(posedge i_master_clock_in); endclocking
   default disable iff (i_rst);
   wire logic win_act = !i_frame_polarity_invert_n;
   wire logic fsp     = o_frame_start_pulse;
   AST_PULSE_ONE: assert property ($rose(fsp) |=> !fsp)
      else $error("frame start pulse longer than one cycle");
   AST_WIN_LEN: assert property ($fell(fsp) && i_mode |->
      (o_frame_window == win_act)[*8] ##1 (o_frame_window == win_act)[*8]
      ##1 (o_frame_window != win_act)) else $error("frame window length");
   AST_OE_SAME: assert property (o_shift_clock_oe == o_serial_result_out_oe
      && o_frame_window_oe == o_frame_start_pulse_oe
      && o_frame_window_oe == o_serial_result_out_oe)
      else $error("output enables disagree");
   AST_OE_OFF: assert property (i_chip_select_n[*4] |-> !o_serial_result_out_oe)
      else $error("outputs driven while deselected");
   AST_TAIL: assert property ($fell(fsp) |-> ##14 !o_serial_result_out
      ##1 !o_serial_result_out) else $error("trailing bits not zero");
   AST_HOLD: assert property ($fell(fsp) && i_mode |-> o_hold_active[*8]
      ##1 o_hold_active[*6] ##1 !o_hold_active) else $error("hold release time");
   AST_NO_RETRIG: assert property ($fell(fsp) && i_mode |-> !fsp[*8]
      ##1 !fsp[*8]) else $error("conversion restarted while running");
   AST_CONT_WIN: assert property ($rose(fsp) && !i_mode |->
      (o_frame_window == i_frame_polarity_invert_n)[*8])
      else $error("frame window moved in continuous mode");
   cover property ($fell(fsp) && i_mode);
   cover property ($rose(fsp) && !i_mode);
   cover property ($fell(o_serial_result_out_oe));
endmodule : adc_ctl_sva

bind adc_conversion_serial_control adc_ctl_sva u_sva (.*);

// *** bench/dsp_port_model.sv ***
// serial port partner: drives the start pins, assembles framed words
`timescale 1ns/100ps
module dsp_port_model (
   input  wire logic  i_master_clock_in,
   input  wire logic  i_serial_result_out,
   input  wire logic  i_serial_result_out_oe,
   input  wire logic  i_frame_start_pulse,
   output logic        o_chip_select_n,
   output logic        o_convert_start_n,
   output logic [15:0] o_word,
   output int          o_frames,
   output int          o_period
);
   logic [15:0] shift_r;
   logic        line_r = 1'b0;
   int          bit_cnt = 0;
   int          cyc = 0;
   int          last_rise = 0;
   // a released line shows a moving pattern, never a stale bit
   wire logic   line = i_serial_result_out_oe ? i_serial_result_out : ~line_r;
   initial begin
      o_chip_select_n = 1'b1;
      o_convert_start_n = 1'b1;
      o_word = 16'h0000;
      o_frames = 0;
      o_period = 0;
   end
   always @(posedge i_master_clock_in) begin
      line_r <= line;
      cyc <= cyc + 1;
      if (bit_cnt > 0) begin
         shift_r = {shift_r[14:0], line};
         bit_cnt <= bit_cnt - 1;
         if (bit_cnt == 1) begin
            o_word <= shift_r;
            o_frames <= o_frames + 1;
         end
      end
      if (i_frame_start_pulse) begin
         bit_cnt <= 16;
         o_period <= cyc - last_rise;
         last_rise <= cyc;
      end
   end
   // pins change just after a link edge; held until the next call
   task automatic set_pins(input logic cs_n, input logic cv_n);
      @(posedge i_master_clock_in);
      #1;
      o_chip_select_n = cs_n;
      o_convert_start_n = cv_n;
   endtask : set_pins
endmodule : dsp_port_model

// *** bench/test_adc_conversion_serial_control.sv ***
// testbench: three start modes, framed words, enables, shift clock phase
`timescale 1ns/100ps
module test_adc_conversion_serial_control;
   logic           i_clock = 1'b0;
   logic           mclk = 1'b0;
   logic           i_rst = 1'b1;
   logic           mode = 1'b1;
   logic           clk_inv_n = 1'b1;
   logic           pol_inv_n = 1'b1;
   adc_pkg::code_t code = 14'h0000;
   adc_pkg::code_t got_r = 14'h0000;
   adc_pkg::code_t rword;
   adc_pkg::code_t codes [4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1555};
   wire logic      cs_n, cv_n, sclk, sclk_oe, sd, sd_oe, win, win_oe;
   wire logic      fsp, fsp_oe, hold, rvalid;
   logic [15:0]    word;
   int             frames, period, n0;
   int             failures = 0;
   int             checked = 0;
   int             ticks = 0;
   initial forever #4 i_clock = ~i_clock;
   initial begin
      #3.3;
      forever #7.5 mclk = ~mclk;
   end
   adc_conversion_serial_control DUT (.i_clock(i_clock), .i_rst(i_rst),
      .i_master_clock_in(mclk), .i_chip_select_n(cs_n),
      .i_convert_start_n(cv_n), .i_mode(mode),
      .i_shift_clock_invert_n(clk_inv_n),
      .i_frame_polarity_invert_n(pol_inv_n), .i_sample_code(code),
      .o_shift_clock(sclk), .o_shift_clock_oe(sclk_oe),
      .o_serial_result_out(sd), .o_serial_result_out_oe(sd_oe),
      .o_frame_window(win), .o_frame_window_oe(win_oe),
      .o_frame_start_pulse(fsp), .o_frame_start_pulse_oe(fsp_oe),
      .o_hold_active(hold), .o_result_word(rword), .o_result_valid(rvalid));
   dsp_port_model u_host (.i_master_clock_in(mclk), .i_serial_result_out(sd),
      .i_serial_result_out_oe(sd_oe), .i_frame_start_pulse(fsp),
      .o_chip_select_n(cs_n), .o_convert_start_n(cv_n), .o_word(word),
      .o_frames(frames), .o_period(period));
   always @(posedge i_clock) if (rvalid === 1'b1) got_r <= rword;
   always @(posedge i_clock) begin
      ticks++;
      if (ticks == 20000) begin
         failures++;
         results();
      end
   end
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic results;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   task automatic do_reset(input logic m);
      @(posedge i_clock);
      #1;
      i_rst = 1'b1;
      mode = m;
      repeat (16) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      repeat (60) @(posedge mclk);
   endtask : do_reset
   // one start, optional retrigger mid conversion, then word and result
   task automatic convert(input logic retrig, input logic cs_i, input logic cv_i,
                          input adc_pkg::code_t c);
      int k;
      n0 = frames;
      code = c;
      u_host.set_pins(1'b0, 1'b0);
      repeat (6) @(posedge mclk);
      if (retrig) u_host.set_pins(1'b0, 1'b1);
      if (retrig) u_host.set_pins(1'b0, 1'b0);
      for (k = 0; k < 200 && frames == n0; k++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      check("frame count", 16'(n0 + 1), 16'(frames));
      check("serial word", {c ^ 14'h2000, 2'b00}, word);
      check("result word", 16'(c ^ 14'h2000), 16'(got_r));
      u_host.set_pins(cs_i, cv_i);
      repeat (60) @(posedge mclk);
   endtask : convert
   initial begin
      do_reset(1'b1);
      u_host.set_pins(1'b0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clock);
         #1;
         {pol_inv_n, clk_inv_n} = 2'(i);
         repeat (10) @(posedge mclk);
         #2;
         check("shift clock high", 16'(clk_inv_n), 16'(sclk));
         @(negedge mclk);
         #2;
         check("shift clock low", 16'(!clk_inv_n), 16'(sclk));
         check("idle window", 16'(pol_inv_n), 16'(win));
         convert(1'b1, 1'b0, 1'b1, codes[i]);
      end
      $display("test convert start mode done");
      do_reset(1'b1);
      u_host.set_pins(1'b1, 1'b0);
      repeat (6) @(posedge mclk);
      check("enables deselected", 16'h0000, 16'(sd_oe | sclk_oe));
      convert(1'b0, 1'b1, 1'b0, 14'h2AAA);
      convert(1'b0, 1'b1, 1'b0, 14'h1FFF);
      check("enables after frame", 16'h0000, 16'(win_oe | fsp_oe));
      $display("test chip select mode done");
      code = 14'h0ABC;
      u_host.set_pins(1'b0, 1'b0);
      do_reset(1'b0);
      check("continuous period", 16'h0010, 16'(period));
      check("continuous word", {14'h0ABC ^ 14'h2000, 2'b00}, word);
      u_host.set_pins(1'b0, 1'b1);
      repeat (20) @(posedge mclk);
      n0 = frames;
      repeat (40) @(posedge mclk);
      check("stopped frames", 16'(n0), 16'(frames));
      $display("test continuous mode done");
      results();
   end
endmodule : test_adc_conversion_serial_control
